// ### shared/mstc_defines.svh
/*
 * Constants of the MAC statistics counter bank: limits, encodings and
 * the host read map. Assumes inclusion by bare name from any design file.
 */
`ifndef MSTC_DEFINES_SVH
`define MSTC_DEFINES_SVH

// ---------------------------------------------------------------------
// Packet length limits in bytes
// ---------------------------------------------------------------------
`define MSTC_MIN_LEN     16'h0040
`define MSTC_MAX_1518    16'h05EE
`define MSTC_MAX_1522    16'h05F2
`define MSTC_MAX_1535    16'h05FF

// Maximum length select codes; 1518 is also the reset value.
`define MSTC_SEL_1518    2'h0
`define MSTC_SEL_1522    2'h1
`define MSTC_SEL_1535    2'h2
`define MSTC_SEL_UNLIM   2'h3

// ---------------------------------------------------------------------
// Counter slots and host read map
// ---------------------------------------------------------------------
`define MSTC_NCTR        13
`define MSTC_NRX         7'h09
`define MSTC_NTX         7'h04
`define MSTC_TX_BASE     7'h12
`define MSTC_FLAG_ADDR   8'hF0

`define MSTC_RX_PKTS     0
`define MSTC_RX_OCTETS   1
`define MSTC_RX_BAD      2
`define MSTC_RX_CRC      3
`define MSTC_RX_ALIGN    4
`define MSTC_RX_SYMBOL   5
`define MSTC_RX_OVERFLOW 6
`define MSTC_RX_LONG     7
`define MSTC_RX_SHORT    8
`define MSTC_TX_PKTS     9
`define MSTC_TX_OCTETS   10
`define MSTC_TX_BAD      11
`define MSTC_TX_UNDERRUN 12

`endif

// ### shared/mstc_pkg.sv
/*
 * Types of the MAC statistics counter bank: the end-of-packet reports
 * of the receive and transmit paths. Assumes nothing else.
 */
package mstc_pkg;

    // Receive end-of-packet report, valid while done is high.
    typedef struct packed {
        logic        done;
        logic [15:0] len;
        logic        fcs_bad;
        logic        odd_bits;
        logic        fifo_ovf;
        logic        bad_code;
        logic        viol;
    } mstc_rx_ev_s;

    // Transmit end-of-packet report, valid while done is high.
    typedef struct packed {
        logic        done;
        logic [15:0] len;
        logic        underrun;
    } mstc_tx_ev_s;

endpackage

// ### core/mstc_ctr_cell.sv
/*
 * One 32-bit statistics counter with read clear, rollover or freeze and
 * a registered pulse when its top bit rises.
 * Assumes a synchronised reset and controls from the sys_clk domain.
 */
`include "mstc_defines.svh"

module mstc_ctr_cell #(
    parameter int W = 32
) (
    // Clock and reset.
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    // Controls.
    input  wire logic         clear,
    input  wire logic         freeze,
    input  wire logic         rd_take,
    input  wire logic         rd_clr_mode,
    input  wire logic         inc_en,
    input  wire logic [W-1:0] inc_amt,
    // State.
    output logic      [W-1:0] value,
    output logic              msb_rise
);

    logic [W-1:0] next_value;
    logic         next_msb_rise;
    logic [W-1:0] base;
    logic [W:0]   sum;

    // Next count: read reset, then one increment per event, with clear overriding both.
    always_comb begin
        base = value;
        sum  = '0;
        if (rd_take && (rd_clr_mode || value == '1)) begin
            base = '0;
        end
        next_value = base;
        if (inc_en) begin
            sum = {1'b0, base} + {1'b0, inc_amt};
            if (sum[W] && freeze) begin
                next_value = '1;
            end else begin
                next_value = sum[W-1:0];
            end
        end
        if (clear) begin
            next_value = '0;
        end
        next_msb_rise = ~value[W-1] & next_value[W-1];
    end

    // Count registers.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            value    <= '0;
            msb_rise <= 1'b0;
        end else begin
            value    <= next_value;
            msb_rise <= next_msb_rise;
        end
    end

    freeze_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        freeze && value == '1 && inc_en && !rd_take && !clear
        |=> value == '1)
        else $error("Frozen counter moved off its maximum.");

endmodule

// ### core/mstc_stats.sv
/*
 * Statistics counter bank of a gigabit MAC: classifies finished packets,
 * counts them and serves reads over the host register pins.
 * Assumes packet reports and configuration come from sys_clk logic and
 * the host pins come from another clock and are synchronised here.
 */
`include "mstc_defines.svh"

module mstc_stats #(
    parameter int NCTR = `MSTC_NCTR
) (
    // Clock and reset.
    input  wire logic                sys_clk,
    input  wire logic                rst_n,
    // Packet reports.
    input  wire mstc_pkg::mstc_rx_ev_s rx_ev,
    input  wire mstc_pkg::mstc_tx_ev_s tx_ev,
    // Configuration.
    input  wire logic [1:0]          stats_max_len_select,
    input  wire logic                ctr_clear_on_read,
    input  wire logic                ctr_freeze,
    input  wire logic                all_counters_clear,
    input  wire logic [NCTR-1:0]     hf_mask,
    // Host register pins.
    input  wire logic                host_if_clock,
    input  wire logic                host_select_low,
    input  wire logic                host_read_low,
    input  wire logic [7:0]          host_addr,
    output logic      [15:0]         host_rdata,
    output logic                     host_rdata_oe,
    output logic                     host_interrupt_out
);

    // -----------------------------------------------------------------
    // Reset release and pin synchronisers
    // -----------------------------------------------------------------
    logic        rst_meta;
    logic        rst_sync_n;
    logic [10:0] pin_meta;
    logic [10:0] pin_sync;
    logic        hclk_s;
    logic        cs_low_s;
    logic        rd_low_s;
    logic [7:0]  addr_s;

    // Reset is released through two flops.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // Host pins pass two flops before any logic reads them.
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pin_meta <= 11'h006;
            pin_sync <= 11'h006;
        end else begin
            pin_meta <= {host_addr, host_read_low, host_select_low,
                         host_if_clock};
            pin_sync <= pin_meta;
        end
    end

    assign hclk_s   = pin_sync[0];
    assign cs_low_s = pin_sync[1];
    assign rd_low_s = pin_sync[2];
    assign addr_s   = pin_sync[10:3];

    // -----------------------------------------------------------------
    // Packet classification
    // -----------------------------------------------------------------
    logic [1:0]             max_sel;
    logic [15:0]            max_len;
    logic                   unlim;
    logic                   rx_legal;
    logic                   rx_sym;
    logic                   rx_bad;
    logic                   tx_legal;
    logic                   tx_bad;
    logic [NCTR-1:0]        inc_en;
    logic [NCTR-1:0][31:0]  inc_amt;

    // The select is held locally so it resets to 1518 bytes.
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            max_sel <= `MSTC_SEL_1518;
        end else begin
            max_sel <= stats_max_len_select;
        end
    end

    // Limit decode; used only for counting, never by the datapath.
    always_comb begin
        unlim = 1'b0;
        unique case (max_sel)
            `MSTC_SEL_1518:  max_len = `MSTC_MAX_1518;
            `MSTC_SEL_1522:  max_len = `MSTC_MAX_1522;
            `MSTC_SEL_1535:  max_len = `MSTC_MAX_1535;
            `MSTC_SEL_UNLIM: begin
                max_len = 16'hFFFF;
                unlim   = 1'b1;
            end
        endcase
    end

    // Good or bad verdicts and the increments they cause.
    always_comb begin
        rx_legal = rx_ev.len >= `MSTC_MIN_LEN &&
                   (unlim || rx_ev.len <= max_len);
        tx_legal = tx_ev.len >= `MSTC_MIN_LEN &&
                   (unlim || tx_ev.len <= max_len);
        rx_sym   = rx_ev.bad_code | rx_ev.viol;
        rx_bad   = ~rx_legal | rx_ev.fcs_bad | rx_ev.fifo_ovf
                   | rx_sym;
        tx_bad   = ~tx_legal | tx_ev.underrun;
        inc_en   = '0;
        for (int i = 0; i < NCTR; i++) begin
            inc_amt[i] = 32'h0000_0001;
        end
        inc_amt[`MSTC_RX_OCTETS] = {16'h0000, rx_ev.len};
        inc_amt[`MSTC_TX_OCTETS] = {16'h0000, tx_ev.len};
        if (rx_ev.done) begin
            inc_en[`MSTC_RX_PKTS]     = ~rx_bad;
            inc_en[`MSTC_RX_OCTETS]   = ~rx_bad;
            inc_en[`MSTC_RX_BAD]      = rx_bad;
            inc_en[`MSTC_RX_CRC]      = rx_ev.fcs_bad & ~rx_ev.odd_bits;
            inc_en[`MSTC_RX_ALIGN]    = rx_ev.fcs_bad & rx_ev.odd_bits;
            inc_en[`MSTC_RX_SYMBOL]   = rx_sym;
            inc_en[`MSTC_RX_OVERFLOW] = rx_ev.fifo_ovf;
            inc_en[`MSTC_RX_LONG]     = ~unlim && rx_ev.len > max_len &&
                                        !(rx_ev.fcs_bad | rx_ev.fifo_ovf
                                          | rx_sym);
            inc_en[`MSTC_RX_SHORT]    = rx_ev.len < `MSTC_MIN_LEN;
        end
        if (tx_ev.done) begin
            inc_en[`MSTC_TX_PKTS]     = ~tx_bad;
            inc_en[`MSTC_TX_OCTETS]   = ~tx_bad;
            inc_en[`MSTC_TX_BAD]      = tx_bad;
            inc_en[`MSTC_TX_UNDERRUN] = tx_ev.underrun;
        end
    end

    // -----------------------------------------------------------------
    // Counter cells
    // -----------------------------------------------------------------
    logic [NCTR-1:0][31:0] ctr_value;
    logic [NCTR-1:0]       hf_rise;
    logic [NCTR-1:0]       rd_take;

    for (genvar i = 0; i < NCTR; i++) begin : g_ctr
        mstc_ctr_cell #(.W(32)) u_cell (
            .sys_clk     (sys_clk),
            .rst_n       (rst_sync_n),
            .clear       (all_counters_clear),
            .freeze      (ctr_freeze),
            .rd_take     (rd_take[i]),
            .rd_clr_mode (ctr_clear_on_read),
            .inc_en      (inc_en[i]),
            .inc_amt     (inc_amt[i]),
            .value       (ctr_value[i]),
            .msb_rise    (hf_rise[i])
        );
    end

    // -----------------------------------------------------------------
    // Host read port, holding word and half-full flags
    // -----------------------------------------------------------------
    logic            hclk_prev;
    logic            rd_was;
    logic            hold_valid;
    logic [3:0]      hold_slot;
    logic [31:0]     hold_val;
    logic [NCTR-1:0] hf_flag;
    logic            next_hclk_prev;
    logic            next_rd_was;
    logic            next_hold_valid;
    logic [3:0]      next_hold_slot;
    logic [31:0]     next_hold_val;
    logic [15:0]     next_rdata;
    logic            next_oe;
    logic [NCTR-1:0] next_flag;
    logic            next_irq;
    logic            hedge;
    logic            rd_lvl;
    logic            acc;
    logic            is_ctr;
    logic [3:0]      slot;
    logic [6:0]      cnum;
    logic [6:0]      tslot;
    logic [31:0]     word;
    logic [NCTR-1:0] clr_mask;

    // Address decode into a counter slot.
    always_comb begin
        cnum   = addr_s[7:1];
        tslot  = cnum - `MSTC_TX_BASE + `MSTC_NRX;
        is_ctr = 1'b0;
        slot   = 4'h0;
        if (cnum < `MSTC_NRX) begin
            is_ctr = 1'b1;
            slot   = cnum[3:0];
        end else if (cnum >= `MSTC_TX_BASE &&
                     cnum < `MSTC_TX_BASE + `MSTC_NTX) begin
            is_ctr = 1'b1;
            slot   = tslot[3:0];
        end
    end

    // One access per host clock edge on which a read starts.
    always_comb begin
        hedge           = hclk_s & ~hclk_prev;
        rd_lvl          = ~cs_low_s & ~rd_low_s;
        acc             = hedge & rd_lvl & ~rd_was;
        next_hclk_prev  = hclk_s;
        next_rd_was     = hedge ? rd_lvl : rd_was;
        next_hold_valid = hold_valid & ~cs_low_s;
        next_hold_slot  = hold_slot;
        next_hold_val   = hold_val;
        next_rdata      = host_rdata;
        next_oe         = rd_lvl;
        rd_take         = '0;
        clr_mask        = '0;
        word            = hold_val;
        if (acc) begin
            next_rdata = 16'h0000;
            if (is_ctr) begin
                if (!(hold_valid && hold_slot == slot)) begin
                    rd_take[slot]   = 1'b1;
                    word            = ctr_value[slot];
                    next_hold_val   = ctr_value[slot];
                    next_hold_slot  = slot;
                    next_hold_valid = 1'b1;
                end
                next_rdata     = addr_s[0] ? word[31:16]
                                           : word[15:0];
                clr_mask[slot] = 1'b1;
            end else if (addr_s == `MSTC_FLAG_ADDR) begin
                next_rdata = 16'(hf_flag);
                clr_mask   = '1;
            end
        end
        next_flag = (hf_flag & ~clr_mask) | hf_rise;
        next_irq  = |(hf_flag & ~hf_mask);
    end

    // Host side registers.
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            hclk_prev          <= 1'b0;
            rd_was             <= 1'b0;
            hold_valid         <= 1'b0;
            hold_slot          <= 4'h0;
            hold_val           <= 32'h0000_0000;
            host_rdata         <= 16'h0000;
            host_rdata_oe      <= 1'b0;
            hf_flag            <= '0;
            host_interrupt_out <= 1'b0;
        end else begin
            hclk_prev          <= next_hclk_prev;
            rd_was             <= next_rd_was;
            hold_valid         <= next_hold_valid;
            hold_slot          <= next_hold_slot;
            hold_val           <= next_hold_val;
            host_rdata         <= next_rdata;
            host_rdata_oe      <= next_oe;
            hf_flag            <= next_flag;
            host_interrupt_out <= next_irq;
        end
    end

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_sync_n);

    short_is_bad_a: assert property (rx_ev.done && rx_ev.len < 16'h0040
        |-> rx_bad && !inc_en[`MSTC_RX_PKTS])
        else $error("Short receive packet counted as good.");
    fcs_split_a: assert property (rx_ev.done && rx_ev.fcs_bad
        |-> inc_en[`MSTC_RX_ALIGN] == rx_ev.odd_bits &&
            inc_en[`MSTC_RX_CRC] == !rx_ev.odd_bits)
        else $error("FCS failure sorted into wrong counter.");
    symbol_err_a: assert property (rx_ev.done && rx_ev.viol
        |-> inc_en[`MSTC_RX_SYMBOL] && inc_en[`MSTC_RX_BAD])
        else $error("Violation group not counted as symbol error.");
    tx_underrun_a: assert property (tx_ev.done && tx_ev.underrun
        |-> inc_en[`MSTC_TX_BAD] && !inc_en[`MSTC_TX_PKTS])
        else $error("Underrun transmit packet not counted bad.");
    limit_1518_a: assert property (max_sel == 2'h0
        |-> max_len == 16'h05EE && !unlim)
        else $error("Select 00 does not give 1518 bytes.");
    global_clear_a: assert property (all_counters_clear
        |=> ctr_value == '0)
        else $error("Global clear left a counter nonzero.");
    flag_latch_a: assert property (hf_rise != '0
        |=> (hf_flag & $past(hf_rise)) == $past(hf_rise))
        else $error("Half-full flag missed its counter rising.");
    irq_follow_a: assert property (##1 host_interrupt_out ==
        $past(|(hf_flag & ~hf_mask)))
        else $error("Interrupt does not follow unmasked flags.");
    read_clear_a: assert property (rd_take[0] && ctr_clear_on_read &&
        !inc_en[0] |=> ctr_value[0] == 32'h0000_0000)
        else $error("Clear-on-read left counter nonzero.");
    no_sel_read_a: assert property (cs_low_s |-> !acc)
        else $error("Read taken while chip select inactive.");

endmodule

// ### dv/mstc_host_model.sv
/*
 * Host processor model on the statistics register pins.
 * Assumes the bank samples the pins through its own synchronisers.
 */
module mstc_host_model (
    // Register pins driven by the host.
    output logic       host_if_clock,
    output logic       host_select_low,
    output logic       host_read_low,
    output logic [7:0] host_addr,
    // Read data returned by the bank.
    input  wire logic [15:0] host_rdata,
    input  wire logic        host_rdata_oe
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle pins; the host clock stands still between accesses.
    initial begin
        host_if_clock   = 1'b0;
        host_select_low = 1'b1;
        host_read_low   = 1'b1;
        host_addr       = 8'h00;
    end

    // One host clock period, slow enough for the synchronisers.
    task automatic pulse;
        #40 host_if_clock = 1'b1;
        #40 host_if_clock = 1'b0;
    endtask

    // One read; the strobe is held until the data has been taken.
    task automatic rd(input logic [7:0] a, input logic sel,
                      output logic [15:0] d, output logic oe);
        host_select_low = ~sel;
        host_read_low   = 1'b0;
        host_addr       = a;
        pulse();
        #30 d = host_rdata;
        oe = host_rdata_oe;
        host_read_low = 1'b1;
        pulse();
    endtask

    // Drop chip select so the next read sees a fresh count.
    task automatic deselect;
        host_select_low = 1'b1;
        host_addr       = ~host_addr;
        pulse();
    endtask
endmodule

// ### dv/mstc_stats_tb.sv
/*
 * Self-checking bench of the statistics counter bank.
 * Assumes the host model file is compiled before this one.
 */
`include "mstc_defines.svh"

module mstc_stats_tb;
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------------------------------
    // Signals and instances
    // ----------------------------------------------------------------
    logic                  sys_clk              = 1'b0;
    logic                  rst_n                = 1'b0;
    mstc_pkg::mstc_rx_ev_s rx_ev                = '0;
    mstc_pkg::mstc_tx_ev_s tx_ev                = '0;
    logic [1:0]            stats_max_len_select = 2'h0;
    logic                  ctr_clear_on_read    = 1'b0;
    logic                  ctr_freeze           = 1'b0;
    logic                  all_counters_clear   = 1'b0;
    logic [12:0]           hf_mask              = 13'h1FFF;
    logic                  host_if_clock;
    logic                  host_select_low;
    logic                  host_read_low;
    logic [7:0]            host_addr;
    logic [15:0]           host_rdata;
    logic                  host_rdata_oe;
    logic                  host_interrupt_out;
    logic [31:0]           exp_ctr [13];
    logic [15:0]           d;
    logic                  oe;
    int                    fail_count = 0;
    int                    n_compared = 0;
    integer                seed       = 17184;

    always #5 sys_clk = ~sys_clk;

    mstc_stats u_mstc_stats (.sys_clk(sys_clk), .rst_n(rst_n),
        .rx_ev(rx_ev), .tx_ev(tx_ev),
        .stats_max_len_select(stats_max_len_select),
        .ctr_clear_on_read(ctr_clear_on_read), .ctr_freeze(ctr_freeze),
        .all_counters_clear(all_counters_clear), .hf_mask(hf_mask),
        .host_if_clock(host_if_clock), .host_select_low(host_select_low),
        .host_read_low(host_read_low), .host_addr(host_addr),
        .host_rdata(host_rdata), .host_rdata_oe(host_rdata_oe),
        .host_interrupt_out(host_interrupt_out));

    mstc_host_model u_mstc_host_model (.host_if_clock(host_if_clock),
        .host_select_low(host_select_low), .host_read_low(host_read_low),
        .host_addr(host_addr), .host_rdata(host_rdata),
        .host_rdata_oe(host_rdata_oe));

    // ----------------------------------------------------------------
    // Checking and expectation helpers
    // ----------------------------------------------------------------
    task automatic cmp_w(input logic [15:0] got, input logic [15:0] want);
        n_compared++;
        if (got !== want) begin
            fail_count++;
            $display("CHECK FAILED %0t word %h expected %h", $time, got, want);
        end
    endtask

    task automatic cmp_b(input logic got, input logic want);
        n_compared++;
        if (got !== want) begin
            fail_count++;
            $display("CHECK FAILED %0t bit %b expected %b", $time, got, want);
        end
    endtask

    // Length limit that the select code stands for.
    function automatic logic [15:0] lim_of(input logic [1:0] s);
        case (s)
            `MSTC_SEL_1518: return `MSTC_MAX_1518;
            `MSTC_SEL_1522: return `MSTC_MAX_1522;
            `MSTC_SEL_1535: return `MSTC_MAX_1535;
            default:        return 16'hFFFF;
        endcase
    endfunction

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // One report on each path; error kinds only on legal lengths.
    task automatic send(input logic [15:0] rl, input logic [15:0] tl,
                        input int rk, input int tk);
        mstc_pkg::mstc_rx_ev_s r;
        mstc_pkg::mstc_tx_ev_s t;
        logic [15:0] lim;
        logic rs, rg, ts, tg, rb, tb;
        lim = lim_of(stats_max_len_select);
        rs = rl < `MSTC_MIN_LEN;
        rg = rl > lim;
        ts = tl < `MSTC_MIN_LEN;
        tg = tl > lim;
        if (rs || rg) rk = 0;
        if (ts || tg) tk = 0;
        r = '0;
        t = '0;
        r.done = 1'b1;
        r.len = rl;
        r.fcs_bad = rk == 1 || rk == 2;
        r.odd_bits = rk == 2;
        r.fifo_ovf = rk == 3;
        r.bad_code = rk == 4 || rk == 6;
        r.viol = rk == 5 || rk == 6;
        t.done = 1'b1;
        t.len = tl;
        t.underrun = tk == 1;
        rb = rs || rg || rk != 0;
        tb = ts || tg || tk != 0;
        exp_ctr[0] += {31'h0, !rb};
        exp_ctr[1] += rb ? 32'h0 : {16'h0000, rl};
        exp_ctr[2] += {31'h0, rb};
        exp_ctr[3] += {31'h0, rk == 1};
        exp_ctr[4] += {31'h0, rk == 2};
        exp_ctr[5] += {31'h0, rk >= 4};
        exp_ctr[6] += {31'h0, rk == 3};
        exp_ctr[7] += {31'h0, rg};
        exp_ctr[8] += {31'h0, rs};
        exp_ctr[9] += {31'h0, !tb};
        exp_ctr[10] += tb ? 32'h0 : {16'h0000, tl};
        exp_ctr[11] += {31'h0, tb};
        exp_ctr[12] += {31'h0, tk == 1};
        @(posedge sys_clk);
        #1;
        rx_ev = r;
        tx_ev = t;
    endtask

    task automatic clear_all;
        wait_cyc(1);
        rx_ev.done = 1'b0;
        tx_ev.done = 1'b0;
        all_counters_clear = 1'b1;
        wait_cyc(1);
        all_counters_clear = 1'b0;
        foreach (exp_ctr[j]) exp_ctr[j] = 32'h0;
    endtask

    // Both halves of one counter, slot numbered as in the map.
    task automatic rd_ctr(input int slot, input logic [31:0] want);
        logic [7:0] a;
        a = 8'((slot < 9 ? slot : slot + 9) * 2);
        u_mstc_host_model.rd(a, 1'b1, d, oe);
        cmp_w(d, want[15:0]);
        u_mstc_host_model.rd(a | 8'h01, 1'b1, d, oe);
        cmp_w(d, want[31:16]);
    endtask

    // Random traffic with boundary lengths, then two read passes.
    task automatic batch(input logic [1:0] s, input logic cor);
        logic [15:0] l;
        logic [15:0] tl;
        stats_max_len_select = s;
        ctr_clear_on_read = cor;
        clear_all();
        for (int i = 0; i < 40; i++) begin
            l = 16'($unsigned($random(seed)) % 1600);
            tl = 16'($unsigned($random(seed)) % 1600);
            if (i == 0) l = 16'h003F;
            if (i == 1) l = 16'h0040;
            if (i == 2) l = lim_of(s);
            if (i == 3) l = lim_of(s) + 16'h0001;
            send(l, tl, $unsigned($random(seed)) % 7,
                 $unsigned($random(seed)) % 2);
        end
        wait_cyc(1);
        rx_ev.done = 1'b0;
        tx_ev.done = 1'b0;
        u_mstc_host_model.deselect();
        u_mstc_host_model.rd(8'h00, 1'b0, d, oe);
        cmp_b(oe, 1'b0);
        for (int j = 0; j < 13; j++) rd_ctr(j, exp_ctr[j]);
        u_mstc_host_model.rd(8'h80, 1'b1, d, oe);
        cmp_w(d, 16'h0000);
        u_mstc_host_model.deselect();
        for (int j = 0; j < 13; j++) begin
            rd_ctr(j, cor ? 32'h0 : exp_ctr[j]);
        end
    endtask

    task complete_run;
        if (fail_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        wait_cyc(6);
        rst_n = 1'b1;
        wait_cyc(3);
        for (int s = 0; s < 4; s++) batch(2'(s), s[0]);
        // Long run of maximum length frames to reach the top bit.
        hf_mask = 13'h1FFF;
        ctr_clear_on_read = 1'b0;
        clear_all();
        repeat (32770) send(16'hFFFF, 16'hFFFF, 0, 0);
        wait_cyc(1);
        rx_ev.done = 1'b0;
        tx_ev.done = 1'b0;
        wait_cyc(4);
        cmp_b(host_interrupt_out, 1'b0);
        hf_mask = 13'h1FFD;
        wait_cyc(3);
        cmp_b(host_interrupt_out, 1'b1);
        u_mstc_host_model.rd(`MSTC_FLAG_ADDR, 1'b1, d, oe);
        cmp_w(d, 16'h0402);
        wait_cyc(4);
        cmp_b(host_interrupt_out, 1'b0);
        u_mstc_host_model.deselect();
        ctr_freeze = 1'b1;
        repeat (32768) send(16'hFFFF, 16'hFFFF, 0, 0);
        wait_cyc(1);
        rx_ev.done = 1'b0;
        tx_ev.done = 1'b0;
        rd_ctr(1, 32'hFFFFFFFF);
        rd_ctr(10, 32'hFFFFFFFF);
        rd_ctr(0, 32'h00010002);
        u_mstc_host_model.deselect();
        rd_ctr(1, 32'h00000000);
        rd_ctr(0, 32'h00010002);
        // A reset pulse in mid-run must zero both packet counters, slots 0 and 9.
        rst_n = 1'b0;
        wait_cyc(2);
        rst_n = 1'b1;
        wait_cyc(3);
        rd_ctr(0, 32'h00000000);
        rd_ctr(9, 32'h00000000);
        complete_run();
    end
endmodule
